// File: verilog/ios_pkg.sv
// Package for the interrupt option and sleep/wake controller
// Behaviour
// - Option register at 0xc8, write only, resets to zero, byte writes only.
// - Bits 7 and 3..0 of the option register do nothing.
// - Bit 6 set makes source one level sensitive, clear makes it edge.
// - Bit 5 chooses the edge direction of source two.
// - Source two rises when bit 5 set, falls when clear; source one edge falls.
// - Bit 4 enables all sources; when clear only the non-maskable one passes.
// - With global enable low the non-maskable is serviced but never wakes.
// - Source three ORs timer zero, low-frequency oscillator, reload timer overflow, compare match and capture edge events, each gated.
// - Source four ORs converter done, receive byte and transmit byte events, each gated.
// - Edge requests latch once, cleared when the service routine starts.
// - Level requests are not stored; low level sampled at instruction end.
// - WAIT stops fetch, keeps state, oscillator and peripherals run.
// - Leaving WAIT by interrupt adds no stabilisation delay.
// - Reset during WAIT or STOP runs the ordinary reset sequence.
// - STOP halts oscillator and execution until any request, internal or external, while bit 4 is set, or reset.
// - Leaving STOP by interrupt inserts an oscillator stabilisation delay.
// - Wake-up leaves the oscillator selection unchanged.
// - Sleep in main program: wake, service request, then continue.
// - Sleep in non-maskable routine: wake, continue, stay non-maskable, no service.
// - Sleep in maskable routine, maskable wake: resume routine, pending serviced later.
// - Sleep in maskable routine, non-maskable wake: run non-maskable first, then resume.
// - Active watchdog turns STOP into WAIT.
// - Global enable low: only reset leaves WAIT or STOP.
// - Sleep is skipped while an enabled request is pending.
package ios_pkg;
    localparam logic [7:0] IOS_OPT_ADDR   = 8'hc8;
    localparam logic [7:0] IOS_OPT_RESET  = 8'h00;
    localparam int         IOS_LES_BIT    = 6;
    localparam int         IOS_ESB_BIT    = 5;
    localparam int         IOS_GEN_BIT    = 4;
    localparam int         IOS_CLK_HZ     = 40_000_000;
    localparam int         IOS_STAB_US    = 100;
    localparam int         IOS_STAB_CYC   = IOS_CLK_HZ / 1_000_000 * IOS_STAB_US;
    localparam int         IOS_CNT_W      = 13;

    typedef enum logic [3:0]
    {
        IOS_RUN  = 4'b0001,
        IOS_WAIT = 4'b0010,
        IOS_STOP = 4'b0100,
        IOS_STAB = 4'b1000
    } ios_pwr_t;

    typedef enum logic [2:0]
    {
        IOS_CTX_MAIN = 3'b001,
        IOS_CTX_IRQ  = 3'b010,
        IOS_CTX_NMI  = 3'b100
    } ios_ctx_t;

    typedef struct packed
    {
        logic timer_zero_flag;
        logic timer_irq_enable;
        logic lowfreq_osc_event;
        logic lowfreq_osc_irq_enable;
        logic reload_timer_overflow_flag;
        logic overflow_irq_enable;
        logic compare_match_flag;
        logic compare_irq_enable;
        logic capture_edge_flag;
        logic edge_irq_enable;
    } ios_src3_t;

    typedef struct packed
    {
        logic adc_eoc_flag;
        logic adc_irq_enable;
        logic rx_byte_ready;
        logic rx_irq_enable;
        logic tx_byte_done;
        logic tx_irq_enable;
    } ios_src4_t;

    typedef struct packed
    {
        logic       wr;
        logic       bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ios_bus_t;
endpackage : ios_pkg

// File: verilog/ios_sync.sv
// Three-stage pin synchroniser with agreement filter
module ios_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] sh_q;

    always_ff @(posedge clk)
    begin
        // Preset to the idle high level so that releasing reset shows no false falling edge
        if (rst)
            sh_q <= 3'h7;
        else
            sh_q <= {sh_q[1:0], pin};
    end

    // Only stages two and three are compared; stage one feeds stage two alone
    always_ff @(posedge clk)
    begin
        if (rst)
            level <= 1'b1;
        else if (sh_q[1] == sh_q[2])
            level <= sh_q[2];
    end
endmodule : ios_sync

// File: verilog/ios_ctrl.sv
// Interrupt option register, request logic and sleep/wake control
module ios_ctrl
(
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire ios_pkg::ios_bus_t bus,
    input  wire logic            nmi_n,
    input  wire logic            src1_n,
    input  wire logic            src2_pin,
    input  wire ios_pkg::ios_src3_t src3,
    input  wire ios_pkg::ios_src4_t src4,
    input  wire logic            instr_end,
    input  wire logic            exec_wait,
    input  wire logic            exec_stop,
    input  wire logic            ack_nmi,
    input  wire logic            ack_src1,
    input  wire logic            ack_src2,
    input  wire logic            reti,
    input  wire logic            wdog_active,
    input  wire logic            osc_sel_in,
    output logic                 req_nmi,
    output logic [4:1]           req_mask,
    output logic                 fetch_halt,
    output logic                 osc_run,
    output logic                 osc_sel,
    output logic                 sleep_skip,
    output logic                 wake_pulse,
    output logic                 wake_service,
    output logic                 in_nmi,
    output logic                 in_irq
);
    logic [7:0]       opt_q;
    logic             nmi_lvl;
    logic             s1_lvl;
    logic             s2_lvl;
    logic             nmi_prev_q;
    logic             s1_prev_q;
    logic             s2_prev_q;
    logic             nmi_lat_q;
    logic             s1_lat_q;
    logic             s2_lat_q;
    logic             level_edge_select;
    logic             edge_polarity_select;
    logic             gen;
    logic             s1_req;
    logic             s3_req;
    logic             s4_req;
    logic             any_mask;
    logic             any_wake;
    logic             sleep_req;
    ios_pkg::ios_pwr_t pwr_q;
    ios_pkg::ios_ctx_t ctx_q;
    ios_pkg::ios_ctx_t ctx_saved_q;
    logic [ios_pkg::IOS_CNT_W-1:0] stab_q;

    function automatic logic gated_or3(input ios_pkg::ios_src3_t s);
        gated_or3 = (s.timer_zero_flag & s.timer_irq_enable)
                  | (s.lowfreq_osc_event & s.lowfreq_osc_irq_enable)
                  | (s.reload_timer_overflow_flag & s.overflow_irq_enable)
                  | (s.compare_match_flag & s.compare_irq_enable)
                  | (s.capture_edge_flag & s.edge_irq_enable);
    endfunction : gated_or3

    function automatic logic gated_or4(input ios_pkg::ios_src4_t s);
        gated_or4 = (s.adc_eoc_flag & s.adc_irq_enable)
                  | (s.rx_byte_ready & s.rx_irq_enable)
                  | (s.tx_byte_done & s.tx_irq_enable);
    endfunction : gated_or4

    ios_sync u_nmi
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (nmi_n),
        .level (nmi_lvl)
    );

    ios_sync u_s1
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (src1_n),
        .level (s1_lvl)
    );

    ios_sync u_s2
    (
        .clk   (clk),
        .rst   (rst),
        .pin   (src2_pin),
        .level (s2_lvl)
    );

    // Write only; single-bit operations are ignored so the register is never read back
    always_ff @(posedge clk)
    begin
        if (rst)
            opt_q <= ios_pkg::IOS_OPT_RESET;
        else if (bus.wr && !bus.bit_op && bus.addr == ios_pkg::IOS_OPT_ADDR)
            opt_q <= bus.wdata & 8'h70;
    end

    assign level_edge_select = opt_q[ios_pkg::IOS_LES_BIT];
    assign edge_polarity_select = opt_q[ios_pkg::IOS_ESB_BIT];
    assign gen = opt_q[ios_pkg::IOS_GEN_BIT];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nmi_prev_q <= 1'b1;
            s1_prev_q  <= 1'b1;
            s2_prev_q  <= 1'b1;
        end
        else
        begin
            nmi_prev_q <= nmi_lvl;
            s1_prev_q  <= s1_lvl;
            s2_prev_q  <= s2_lvl;
        end
    end

    // Edge latches: set wins over the acknowledge, later edges merge into the first
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nmi_lat_q <= 1'b0;
            s1_lat_q  <= 1'b0;
            s2_lat_q  <= 1'b0;
        end
        else
        begin
            if (nmi_prev_q && !nmi_lvl)
                nmi_lat_q <= 1'b1;
            else if (ack_nmi)
                nmi_lat_q <= 1'b0;
            if (!level_edge_select && s1_prev_q && !s1_lvl)
                s1_lat_q <= 1'b1;
            else if (ack_src1 || level_edge_select)
                s1_lat_q <= 1'b0;
            if (edge_polarity_select ? (!s2_prev_q && s2_lvl) : (s2_prev_q && !s2_lvl))
                s2_lat_q <= 1'b1;
            else if (ack_src2)
                s2_lat_q <= 1'b0;
        end
    end

    assign s1_req   = level_edge_select ? !s1_lvl : s1_lat_q;
    assign s3_req   = gated_or3(src3);
    assign s4_req   = gated_or4(src4);
    assign any_mask = gen && (s1_req || s2_lat_q || s3_req || s4_req);
    assign any_wake = gen && (any_mask || nmi_lat_q);
    assign sleep_req = exec_wait || exec_stop;

    // Level requests are presented only at instruction end, never held
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_nmi  <= 1'b0;
            req_mask <= 4'h0;
        end
        else
        begin
            req_nmi     <= nmi_lat_q;
            req_mask[1] <= gen && s1_req && (level_edge_select ? instr_end : 1'b1);
            req_mask[2] <= gen && s2_lat_q;
            req_mask[3] <= gen && s3_req && instr_end;
            req_mask[4] <= gen && s4_req && instr_end;
        end
    end

    // Processor context tracking
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctx_q       <= ios_pkg::IOS_CTX_MAIN;
            ctx_saved_q <= ios_pkg::IOS_CTX_MAIN;
        end
        else if (ack_nmi)
        begin
            ctx_saved_q <= ctx_q;
            ctx_q       <= ios_pkg::IOS_CTX_NMI;
        end
        else if (ack_src1 || ack_src2)
            ctx_q <= ios_pkg::IOS_CTX_IRQ;
        else if (reti)
            ctx_q <= (ctx_q == ios_pkg::IOS_CTX_NMI) ? ctx_saved_q : ios_pkg::IOS_CTX_MAIN;
    end

    // Power state machine
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwr_q        <= ios_pkg::IOS_RUN;
            stab_q       <= '0;
            sleep_skip   <= 1'b0;
            wake_pulse   <= 1'b0;
            wake_service <= 1'b0;
        end
        else
        begin
            sleep_skip   <= 1'b0;
            wake_pulse   <= 1'b0;
            wake_service <= 1'b0;
            case (pwr_q)
                ios_pkg::IOS_RUN:
                begin
                    if (sleep_req && (any_mask || nmi_lat_q))
                        sleep_skip <= 1'b1;
                    else if (exec_stop && !wdog_active)
                        pwr_q <= ios_pkg::IOS_STOP;
                    else if (sleep_req)
                        pwr_q <= ios_pkg::IOS_WAIT;
                end
                ios_pkg::IOS_WAIT:
                begin
                    if (any_wake)
                    begin
                        pwr_q        <= ios_pkg::IOS_RUN;
                        wake_pulse   <= 1'b1;
                        wake_service <= (ctx_q != ios_pkg::IOS_CTX_NMI)
                                        && ((ctx_q == ios_pkg::IOS_CTX_MAIN) || nmi_lat_q);
                    end
                end
                ios_pkg::IOS_STOP:
                begin
                    if (any_wake)
                    begin
                        pwr_q  <= ios_pkg::IOS_STAB;
                        stab_q <= ios_pkg::IOS_CNT_W'(ios_pkg::IOS_STAB_CYC - 1);
                    end
                end
                ios_pkg::IOS_STAB:
                begin
                    if (stab_q == '0)
                    begin
                        pwr_q        <= ios_pkg::IOS_RUN;
                        wake_pulse   <= 1'b1;
                        wake_service <= (ctx_q != ios_pkg::IOS_CTX_NMI)
                                        && ((ctx_q == ios_pkg::IOS_CTX_MAIN) || nmi_lat_q);
                    end
                    else
                        stab_q <= stab_q - 1'b1;
                end
                default:
                    pwr_q <= ios_pkg::IOS_RUN;
            endcase
        end
    end

    // Registered status outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fetch_halt <= 1'b0;
            osc_run    <= 1'b1;
            osc_sel    <= 1'b0;
            in_nmi     <= 1'b0;
            in_irq     <= 1'b0;
        end
        else
        begin
            fetch_halt <= (pwr_q != ios_pkg::IOS_RUN);
            osc_run    <= (pwr_q != ios_pkg::IOS_STOP);
            if (pwr_q == ios_pkg::IOS_RUN)
                osc_sel <= osc_sel_in;
            in_nmi     <= (ctx_q == ios_pkg::IOS_CTX_NMI);
            in_irq     <= (ctx_q == ios_pkg::IOS_CTX_IRQ);
        end
    end

    property p_bitop_ignored;
        @(posedge clk) disable iff (rst)
        (bus.wr && bus.bit_op) |=> $stable(opt_q);
    endproperty
    a_bitop_ignored: assert property (p_bitop_ignored) else $error("bit op changed option reg");

    property p_unused_zero;
        @(posedge clk) disable iff (rst)
        (opt_q[7] == 1'b0) && (opt_q[3:0] == 4'h0);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused option bits set");

    property p_gen_blocks;
        @(posedge clk) disable iff (rst)
        !gen |=> (req_mask == 4'h0);
    endproperty
    a_gen_blocks: assert property (p_gen_blocks) else $error("masked request passed");

    property p_no_wake_gen_low;
        @(posedge clk) disable iff (rst)
        ((pwr_q == ios_pkg::IOS_WAIT) && !gen) |=> (pwr_q == ios_pkg::IOS_WAIT);
    endproperty
    a_no_wake_gen_low: assert property (p_no_wake_gen_low) else $error("woke with gen low");

    property p_wait_fast;
        @(posedge clk) disable iff (rst)
        ((pwr_q == ios_pkg::IOS_WAIT) && any_wake) |=> (pwr_q == ios_pkg::IOS_RUN) && wake_pulse;
    endproperty
    a_wait_fast: assert property (p_wait_fast) else $error("wait exit delayed");

    sequence s_stop_woken;
        (pwr_q == ios_pkg::IOS_STOP) && any_wake;
    endsequence

    property p_stop_stab;
        @(posedge clk) disable iff (rst)
        s_stop_woken |=> (pwr_q == ios_pkg::IOS_STAB) [*8];
    endproperty
    a_stop_stab: assert property (p_stop_stab) else $error("stop exit too fast");

    property p_wdog_no_stop;
        @(posedge clk) disable iff (rst)
        wdog_active |=> (pwr_q != ios_pkg::IOS_STOP) || ($past(pwr_q) == ios_pkg::IOS_STOP);
    endproperty
    a_wdog_no_stop: assert property (p_wdog_no_stop) else $error("stop entered with watchdog");

    property p_skip_pending;
        @(posedge clk) disable iff (rst)
        ((pwr_q == ios_pkg::IOS_RUN) && sleep_req && any_mask) |=> sleep_skip && (pwr_q == ios_pkg::IOS_RUN);
    endproperty
    a_skip_pending: assert property (p_skip_pending) else $error("slept with pending request");

    property p_nmi_no_service;
        @(posedge clk) disable iff (rst)
        ((pwr_q == ios_pkg::IOS_WAIT) && any_wake && (ctx_q == ios_pkg::IOS_CTX_NMI)) |=> !wake_service;
    endproperty
    a_nmi_no_service: assert property (p_nmi_no_service) else $error("serviced inside nmi");

    property p_osc_stop;
        @(posedge clk) disable iff (rst)
        (pwr_q == ios_pkg::IOS_STOP) |=> !osc_run;
    endproperty
    a_osc_stop: assert property (p_osc_stop) else $error("oscillator ran in stop");

    // Only the running core may change the oscillator choice; waking never touches it
    property p_osc_sel_kept;
        @(posedge clk) disable iff (rst)
        (pwr_q != ios_pkg::IOS_RUN) |=> $stable(osc_sel);
    endproperty
    a_osc_sel_kept: assert property (p_osc_sel_kept) else $error("oscillator choice changed asleep");
endmodule : ios_ctrl

// File: testbench/ios_core_model.sv
// Core-side partner model: paces instruction ends while the core fetches
module ios_core_model
#(
    parameter int INSTR_CYC = 4
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic fetch_halt,
    input  wire logic osc_run,
    output logic      instr_end
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    initial
    begin
        instr_end = 1'b0;
        cnt = 0;
    end
    // No instruction ends while halted or unclocked, so level sources reach req_mask only while the core runs
    always @(posedge clk)
    begin
        #2;
        cnt = (rst || fetch_halt || !osc_run) ? 0 : cnt + 1;
        instr_end = (cnt == INSTR_CYC);
        if (cnt == INSTR_CYC)
            cnt = 0;
    end
endmodule : ios_core_model

// File: testbench/tb.sv
// Self-checking bench for the interrupt option and sleep/wake controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, rst, nmi_n, src1_n, src2_pin, instr_end, exec_wait, exec_stop;
    logic              ack_nmi, ack_src1, ack_src2, reti, wdog_active, osc_sel_in;
    logic              req_nmi, fetch_halt, osc_run, osc_sel, sleep_skip, wake_pulse, wake_service;
    logic              in_nmi, in_irq, o;
    logic [4:1]        req_mask, sn;
    ios_pkg::ios_bus_t bus;
    ios_pkg::ios_src3_t src3;
    ios_pkg::ios_src4_t src4;
    logic [31:0]       seed, r;
    int                error_cnt, compares, glob_en_m, w;

    ios_ctrl uut (.clk(clk), .rst(rst), .bus(bus), .nmi_n(nmi_n), .src1_n(src1_n), .src2_pin(src2_pin),
        .src3(src3), .src4(src4), .instr_end(instr_end), .exec_wait(exec_wait), .exec_stop(exec_stop),
        .ack_nmi(ack_nmi), .ack_src1(ack_src1), .ack_src2(ack_src2), .reti(reti), .wdog_active(wdog_active),
        .osc_sel_in(osc_sel_in), .req_nmi(req_nmi), .req_mask(req_mask), .fetch_halt(fetch_halt),
        .osc_run(osc_run), .osc_sel(osc_sel), .sleep_skip(sleep_skip), .wake_pulse(wake_pulse),
        .wake_service(wake_service), .in_nmi(in_nmi), .in_irq(in_irq));
    ios_core_model core (.clk(clk), .rst(rst), .fetch_halt(fetch_halt), .osc_run(osc_run),
        .instr_end(instr_end));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // Expected level request: any event whose own enable is set
    function automatic logic lvl_hit(input logic [9:0] v, input int pairs);
        logic h;
        h = 1'b0;
        for (int i = 0; i < pairs; i++)
            if (v[2 * i + 1] && v[2 * i])
                h = 1'b1;
        return h;
    endfunction : lvl_hit

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    // Level requests stand for one cycle after an instruction end, so watch a whole instruction
    task automatic seen(output logic [4:1] s);
        s = 4'h0;
        repeat (5)
        begin
            tick(1);
            s = s | req_mask;
        end
    endtask : seen

    task automatic complete_run();
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic a, input logic e, input string m);
        compares++;
        if (a !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk

    task automatic wr_opt(input logic [7:0] a, input logic [7:0] d, input logic b);
        bus = '{wr: 1'b1, bit_op: b, addr: a, wdata: d};
        tick(1);
        bus.wr = 1'b0;
    endtask : wr_opt

    task automatic pulse(input int k);
        case (k)
            0: ack_nmi = 1'b1;
            1: ack_src1 = 1'b1;
            2: ack_src2 = 1'b1;
            default: reti = 1'b1;
        endcase
        tick(1);
        {ack_nmi, ack_src1, ack_src2, reti} = 4'h0;
        tick(1);
    endtask : pulse

    task automatic sleep(input logic stop);
        if (stop)
            exec_stop = 1'b1;
        else
            exec_wait = 1'b1;
        tick(1);
        {exec_stop, exec_wait} = 2'b00;
        tick(2);
        chk(fetch_halt, 1'b1, "no halt");
    endtask : sleep

    task automatic rise2();
        src2_pin = 1'b0;
        tick(6);
        src2_pin = 1'b1;
    endtask : rise2

    task automatic wake(input int lo, input int hi, input logic svc);
        int n;
        n = 0;
        while (wake_pulse !== 1'b1 && n < hi)
        begin
            tick(1);
            n++;
        end
        chk(n >= lo && n < hi, 1'b1, "wake time");
        if (n >= hi)
            complete_run();
        chk(wake_service, svc, "wake service");
        tick(1);
    endtask : wake

    initial
    begin
        {rst, nmi_n, src1_n, src2_pin, osc_sel_in} = 5'h1f;
        {exec_wait, exec_stop, ack_nmi, ack_src1, ack_src2, reti, wdog_active} = 7'h00;
        bus = '0;
        src3 = '0;
        src4 = '0;
        seed = 32'h9fea;
        {error_cnt, compares, glob_en_m} = 0;
        tick(4);
        rst = 1'b0;
        chk(req_mask == 4'h0, 1'b1, "reset req");
        for (int k = 0; k < 12; k++)
        begin
            if (k == 3)
                wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h10, 1'b1);
            if (k == 5)
                wr_opt(8'hc9, 8'h10, 1'b0);
            if (k == 7)
            begin
                wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h9f, 1'b0);
                glob_en_m = 1;
            end
            r = next_rand();
            src3 = r[9:0];
            src4 = r[15:10];
            tick(5);
            seen(sn);
            chk(sn[3], glob_en_m[0] & lvl_hit(r[9:0], 5), "src3");
            chk(sn[4], glob_en_m[0] & lvl_hit({4'h0, r[15:10]}, 3), "src4");
        end
        src3 = '0;
        src4 = '0;
        wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h50, 1'b0);
        src1_n = 1'b0;
        tick(7);
        seen(sn);
        chk(sn[1], 1'b1, "lvl on");
        src1_n = 1'b1;
        tick(7);
        seen(sn);
        chk(sn[1], 1'b0, "lvl kept");
        wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h10, 1'b0);
        src1_n = 1'b0;
        tick(8);
        src1_n = 1'b1;
        tick(12);
        chk(req_mask[1], 1'b1, "src1 edge");
        pulse(1);
        chk(req_mask[1], 1'b0, "src1 ack");
        pulse(3);
        src2_pin = 1'b0;
        tick(10);
        chk(req_mask[2], 1'b1, "src2 fall");
        src2_pin = 1'b1;
        pulse(2);
        tick(8);
        chk(req_mask[2], 1'b0, "src2 rise");
        pulse(3);
        src3 = 10'h300;
        tick(10);
        exec_wait = 1'b1;
        tick(1);
        exec_wait = 1'b0;
        chk(sleep_skip, 1'b1, "skip");
        tick(2);
        chk(fetch_halt, 1'b0, "skip halt");
        src3 = '0;
        wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h30, 1'b0);
        tick(10);
        sleep(1'b0);
        chk(osc_run, 1'b1, "wait osc");
        rise2();
        wake(0, 12, 1'b1);
        chk(fetch_halt, 1'b0, "resume");
        pulse(2);
        pulse(3);
        chk(req_mask[2], 1'b0, "latch clr");
        wdog_active = 1'b1;
        sleep(1'b1);
        chk(osc_run, 1'b1, "wdog stop");
        rise2();
        wake(0, 12, 1'b1);
        pulse(2);
        pulse(3);
        wdog_active = 1'b0;
        o = osc_sel;
        sleep(1'b1);
        chk(osc_run, 1'b0, "stop osc");
        rise2();
        wake(ios_pkg::IOS_STAB_CYC, ios_pkg::IOS_STAB_CYC + 20, 1'b1);
        chk(osc_sel, o, "osc sel");
        chk(osc_run, 1'b1, "osc back");
        pulse(2);
        pulse(3);
        nmi_n = 1'b0;
        tick(8);
        chk(req_nmi, 1'b1, "nmi req");
        pulse(0);
        nmi_n = 1'b1;
        chk(in_nmi, 1'b1, "in nmi");
        sleep(1'b0);
        rise2();
        wake(0, 12, 1'b0);
        chk(in_nmi, 1'b1, "stay nmi");
        pulse(3);
        pulse(2);
        chk(in_irq, 1'b1, "in irq");
        sleep(1'b0);
        rise2();
        wake(0, 12, 1'b0);
        chk(in_irq, 1'b1, "stay irq");
        pulse(2);
        sleep(1'b0);
        nmi_n = 1'b0;
        wake(0, 12, 1'b1);
        nmi_n = 1'b1;
        pulse(0);
        pulse(3);
        chk(in_irq, 1'b1, "irq after nmi");
        pulse(3);
        // Global enable off: the NMI still latches but must not wake the core
        wr_opt(ios_pkg::IOS_OPT_ADDR, 8'h20, 1'b0);
        tick(4);
        sleep(1'b0);
        nmi_n = 1'b0;
        w = 0;
        repeat (40)
        begin
            tick(1);
            if (wake_pulse === 1'b1)
                w = 1;
        end
        chk(w == 0, 1'b1, "woke");
        chk(req_nmi, 1'b1, "nmi off");
        chk(fetch_halt, 1'b1, "halt kept");
        nmi_n = 1'b1;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        chk(fetch_halt | req_nmi | ~osc_run, 1'b0, "sleep reset");
        complete_run();
    end
endmodule : tb
